// [core/hie3_armed.sv]
// Read-zero tracker that qualifies a later write of one to a status-gated bit.
`default_nettype none
module hie3_armed
    import hie3_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic clr,
    input  wire logic rd,
    input  wire logic wr,
    input  wire logic bit_val,
    output logic      armed
);
    logic armed_r;

    // A read that sees zero arms; any write consumes the arming.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            armed_r <= HIE3_ARMED_RESET;
        end else if (clr || wr) begin
            armed_r <= 1'b0;
        end else if (rd && !bit_val) begin
            armed_r <= 1'b1;
        end
    end

    assign armed = armed_r;
endmodule
`default_nettype wire

// [core/hie3_pkg.sv]
// Package of constants for the channel-3 host IRQ10 enable bit block.
`default_nettype none
package hie3_pkg;
    localparam int   HIE3_EN_BIT      = 6;
    localparam logic HIE3_EN_RESET    = 1'b0;
    localparam logic HIE3_ARMED_RESET = 1'b0;
    localparam logic HIE3_FLAG_RESET  = 1'b0;
    localparam logic HIE3_IRQ_RESET   = 1'b0;
endpackage
`default_nettype wire

// [core/hie3_top.sv]
// Channel-3 host interrupt-10 enable bit with direct-request mode.
`default_nettype none
module hie3_top
    import hie3_pkg::*;
(
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       LPC_HW_RESET,
    input  wire logic       LPC_SW_RESET,
    input  wire logic       SLV_RD,
    input  wire logic       SLV_WR,
    input  wire logic [7:0] SLV_WDATA,
    input  wire logic       DIRECT_REQUEST_MODE_3,
    input  wire logic       OUTPUT_FULL_FLAG_3,
    output logic            HOST_IRQ10_ENABLE_3,
    output logic            HOST_INTERRUPT_LINE_10
);
    // ***************************************************************
    // State
    // ***************************************************************
    logic en_r;
    logic en_nxt;
    logic obf_r;
    logic irq_r;
    logic irq_nxt;
    logic armed;
    logic lpc_rst;
    logic obf_fall;
    logic wr_bit;

    assign lpc_rst  = LPC_HW_RESET || LPC_SW_RESET;
    // The flag is set by the output data register 3 write elsewhere. 
    assign obf_fall = obf_r && !OUTPUT_FULL_FLAG_3;
    assign wr_bit   = SLV_WDATA[HIE3_EN_BIT];

    hie3_armed u_armed (
        .clk     (CORE_CLK),
        .rst     (RST),
        .clr     (lpc_rst),
        .rd      (SLV_RD),
        .wr      (SLV_WR),
        .bit_val (en_r),
        .armed   (armed)
    );

    // ***************************************************************
    // Enable bit
    // ***************************************************************
    // Clears take priority over a qualified set in the same cycle, since
    // a fall of the flag means the host already drained the data.
    always_comb begin
        en_nxt = en_r;
        if (lpc_rst) begin
            en_nxt = 1'b0;
        end else if (!DIRECT_REQUEST_MODE_3 && obf_fall) begin
            en_nxt = 1'b0;
        end else if (SLV_WR && !wr_bit) begin
            en_nxt = 1'b0;
        end else if (SLV_WR && wr_bit && armed) begin
            en_nxt = 1'b1;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            en_r <= HIE3_EN_RESET;
        end else begin
            en_r <= en_nxt;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            obf_r <= HIE3_FLAG_RESET;
        end else begin
            obf_r <= OUTPUT_FULL_FLAG_3;
        end
    end

    // ***************************************************************
    // Request toward the host
    // ***************************************************************
    always_comb begin
        if (DIRECT_REQUEST_MODE_3) begin
            irq_nxt = en_nxt;
        end else begin
            irq_nxt = en_nxt && OUTPUT_FULL_FLAG_3;
        end
    end

    always_ff @(posedge CORE_CLK or posedge RST) begin
        if (RST) begin
            irq_r <= HIE3_IRQ_RESET;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign HOST_IRQ10_ENABLE_3    = en_r;
    assign HOST_INTERRUPT_LINE_10 = irq_r;

    // ***************************************************************
    // Checks
    // ***************************************************************
    property p_wr_zero;
        @(posedge CORE_CLK) disable iff (RST)
        SLV_WR && !wr_bit |=> !HOST_IRQ10_ENABLE_3;
    endproperty
    a_wr_zero: assert property (p_wr_zero)
        else $error("enable not cleared by zero write");

    property p_lpc_rst;
        @(posedge CORE_CLK) disable iff (RST)
        LPC_HW_RESET || LPC_SW_RESET |=> !HOST_IRQ10_ENABLE_3;
    endproperty
    a_lpc_rst: assert property (p_lpc_rst)
        else $error("enable not cleared by lpc reset");

    property p_obf_fall;
        @(posedge CORE_CLK) disable iff (RST)
        !DIRECT_REQUEST_MODE_3 && $fell(OUTPUT_FULL_FLAG_3)
            |=> !HOST_IRQ10_ENABLE_3;
    endproperty
    a_obf_fall: assert property (p_obf_fall)
        else $error("enable not cleared on flag fall");

    property p_norm_irq;
        @(posedge CORE_CLK) disable iff (RST)
        !DIRECT_REQUEST_MODE_3 |=>
            HOST_INTERRUPT_LINE_10 ==
            (HOST_IRQ10_ENABLE_3 && $past(OUTPUT_FULL_FLAG_3));
    endproperty
    a_norm_irq: assert property (p_norm_irq)
        else $error("normal mode request mismatch");

    property p_dir_irq;
        @(posedge CORE_CLK) disable iff (RST)
        DIRECT_REQUEST_MODE_3 |=>
            HOST_INTERRUPT_LINE_10 == HOST_IRQ10_ENABLE_3;
    endproperty
    a_dir_irq: assert property (p_dir_irq)
        else $error("direct mode request mismatch");

    property p_set_qual;
        @(posedge CORE_CLK) disable iff (RST)
        !HOST_IRQ10_ENABLE_3 ##1 HOST_IRQ10_ENABLE_3
            |-> $past(SLV_WR) && $past(wr_bit) && $past(armed);
    endproperty
    a_set_qual: assert property (p_set_qual)
        else $error("enable set without qualified write");

    property p_arm;
        @(posedge CORE_CLK) disable iff (RST)
        SLV_RD && !SLV_WR && !HOST_IRQ10_ENABLE_3 && !lpc_rst |=> armed;
    endproperty
    a_arm: assert property (p_arm)
        else $error("zero read did not arm");

    property p_set_ok;
        @(posedge CORE_CLK) disable iff (RST)
        SLV_WR && wr_bit && armed && !lpc_rst && !obf_fall
            |=> HOST_IRQ10_ENABLE_3;
    endproperty
    a_set_ok: assert property (p_set_ok)
        else $error("qualified write did not set");

    // The record is a one-shot: every write and every LPC reset drops it,
    // so a read can qualify only the first write that follows it, however much later.
    property p_lpc_disarm;
        @(posedge CORE_CLK) disable iff (RST)
        lpc_rst |=> !armed;
    endproperty
    a_lpc_disarm: assert property (p_lpc_disarm)
        else $error("lpc reset did not drop the read record");

    property p_wr_disarm;
        @(posedge CORE_CLK) disable iff (RST)
        SLV_WR |=> !armed;
    endproperty
    a_wr_disarm: assert property (p_wr_disarm)
        else $error("write did not drop the read record");

    property p_rd_one;
        @(posedge CORE_CLK) disable iff (RST)
        SLV_RD && HOST_IRQ10_ENABLE_3 && !armed |=> !armed;
    endproperty
    a_rd_one: assert property (p_rd_one)
        else $error("read of one armed the set");

    property p_en_hold;
        @(posedge CORE_CLK) disable iff (RST)
        !SLV_WR && !lpc_rst && (DIRECT_REQUEST_MODE_3 || !obf_fall)
            |=> $stable(HOST_IRQ10_ENABLE_3);
    endproperty
    a_en_hold: assert property (p_en_hold)
        else $error("enable changed with no cause");

    property p_dir_keep;
        @(posedge CORE_CLK) disable iff (RST)
        DIRECT_REQUEST_MODE_3 && obf_fall && HOST_IRQ10_ENABLE_3 &&
            !SLV_WR && !lpc_rst |=> HOST_IRQ10_ENABLE_3;
    endproperty
    a_dir_keep: assert property (p_dir_keep)
        else $error("flag fall cleared enable in direct mode");

    // The line can never run ahead of the enable, in either mode.
    property p_irq_en;
        @(posedge CORE_CLK) disable iff (RST)
        HOST_INTERRUPT_LINE_10 |-> HOST_IRQ10_ENABLE_3;
    endproperty
    a_irq_en: assert property (p_irq_en)
        else $error("request raised while enable is clear");

    property p_dir_set;
        @(posedge CORE_CLK) disable iff (RST)
        DIRECT_REQUEST_MODE_3 && SLV_WR && wr_bit && armed && !lpc_rst
            |=> HOST_INTERRUPT_LINE_10;
    endproperty
    a_dir_set: assert property (p_dir_set)
        else $error("direct mode set did not raise request");
endmodule
`default_nettype wire

// [test/hie3_host_model.sv]
// Host-side model that owns the channel-3 output-full flag.
`default_nettype none
module hie3_host_model (
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic odr_wr,
    input  wire logic host_rd,
    output logic      full_flag_r
);
    // The flag is set by an output data write and cleared by a host read.
    always_ff @(posedge clk or posedge rst) begin
        if (rst)
            full_flag_r <= 1'b0;
        else if (odr_wr)
            full_flag_r <= 1'b1;
        else if (host_rd)
            full_flag_r <= 1'b0;
    end
endmodule
`default_nettype wire

// [test/hie3_top_test.sv]
// Self-checking bench for the channel-3 host IRQ10 enable bit.
`default_nettype none
module hie3_top_test import hie3_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst = 1'b1, hw = 1'b0, sw = 1'b0, rd = 1'b0;
    logic wr = 1'b0, md = 1'b0, odr = 1'b0, hrd = 1'b0, en, irq, flag;
    logic [7:0] wd = 8'h00;
    int failures = 0, n_checks = 0;
    hie3_top u_dut (.CORE_CLK(clk), .RST(rst), .LPC_HW_RESET(hw),
        .LPC_SW_RESET(sw), .SLV_RD(rd), .SLV_WR(wr), .SLV_WDATA(wd),
        .DIRECT_REQUEST_MODE_3(md), .OUTPUT_FULL_FLAG_3(flag),
        .HOST_IRQ10_ENABLE_3(en), .HOST_INTERRUPT_LINE_10(irq));
    hie3_host_model u_host (.clk(clk), .rst(rst), .odr_wr(odr),
        .host_rd(hrd), .full_flag_r(flag));
    // ************************************
    // Shared drivers and comparison
    // ************************************
    task automatic chk(input logic got, input logic exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask
    localparam int P_RD  = 0;
    localparam int P_ODR = 1;
    localparam int P_HRD = 2;
    localparam int P_HW  = 3;
    localparam int P_SW  = 4;
    task automatic drive(input int which, input logic v);
        case (which)
            P_RD:    rd  <= v;
            P_ODR:   odr <= v;
            P_HRD:   hrd <= v;
            P_HW:    hw  <= v;
            P_SW:    sw  <= v;
            default: ;
        endcase
    endtask
    // A pulse is held across exactly one sampling edge.
    task automatic pulse(input int which);
        @(posedge clk);
        drive(which, 1'b1);
        @(posedge clk);
        drive(which, 1'b0);
        #1;
    endtask
    task automatic wr_en(input logic b);
        @(posedge clk);
        wd <= 8'(b) << HIE3_EN_BIT;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic arm_set;
        pulse(P_RD);
        wr_en(1'b1);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    // ************************************
    // Scenarios
    // ************************************
    task automatic t_init;
        chk(en, HIE3_EN_RESET);
        wr_en(1'b1);
        chk(en, 1'b0);
        $display("init done");
    endtask
    task automatic t_normal;
        pulse(P_ODR);
        @(posedge clk);
        #1;
        chk(irq, 1'b0);
        pulse(P_HRD);
        arm_set;
        chk(en, 1'b1);
        chk(irq, 1'b0);
        pulse(P_RD);
        pulse(P_ODR);
        @(posedge clk);
        #1;
        chk(irq, 1'b1);
        pulse(P_HRD);
        @(posedge clk);
        #1;
        chk(en, 1'b0);
        chk(irq, 1'b0);
        wr_en(1'b1);
        chk(en, 1'b0);
        $display("normal done");
    endtask
    task automatic t_clear;
        arm_set;
        chk(en, 1'b1);
        wr_en(1'b0);
        chk(en, 1'b0);
        wr_en(1'b1);
        chk(en, 1'b0);
        arm_set;
        chk(en, 1'b1);
        pulse(P_HW);
        chk(en, 1'b0);
        arm_set;
        chk(en, 1'b1);
        pulse(P_SW);
        chk(en, 1'b0);
        pulse(P_RD);
        pulse(P_HW);
        wr_en(1'b1);
        chk(en, 1'b0);
        $display("clear done");
    endtask
    task automatic t_direct;
        @(posedge clk);
        md <= 1'b1;
        arm_set;
        chk(irq, 1'b1);
        pulse(P_ODR);
        pulse(P_HRD);
        @(posedge clk);
        #1;
        chk(en, 1'b1);
        chk(irq, 1'b1);
        $display("direct done");
    endtask
    initial begin
        forever #25 clk = ~clk;
    end
    initial begin
        #20000;
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_init();
        t_normal();
        t_clear();
        t_direct();
        tally_and_finish();
    end
endmodule
`default_nettype wire
